//--- bench/testbench.sv
// Self-checking bench for exit recording and event reinjection
`timescale 1ns/1ps
`include "vmeer_defs.svh"
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_fail++; \
    $display("wrong value %s expected %h seen %h", nm, e, g); end end

module testbench;
    logic        clk = 0, arst_n = 0, nmi_exiting = 0, virtual_nmis = 0, exit_evt = 0;
    logic        exit_errv = 0, interrupt_return_unblocked = 0, nmi_blocked_now = 0, deliv_active = 0;
    logic        deliv_errv = 0, go = 0, keep_rsv = 0, keep_nmi = 0;
    logic [2:0]  exit_type = 3'h3, deliv_type = 3'h0;
    logic [3:0]  exit_insn_len = 4'h3, exit_lp_id = 4'h2, resume_lp_id = 4'h2;
    logic [7:0]  exit_vector = 8'h0, deliv_vector = 8'h0;
    logic [31:0] exit_err_code = 32'h0, deliv_err_code = 32'h0000_1234;
    logic        entry_ok_q, entry_fail_q, inject_q, inject_errv_q, busy_q, resume_req;
    logic        wr_entry_info, wr_entry_err, wr_entry_len, wr_intr_state;
    logic [2:0]  inject_type_q;
    logic [3:0]  exit_len_q, inject_len_q, wr_entry_len_data;
    logic [7:0]  inject_vector_q;
    logic [31:0] exit_info_q, exit_err_q, vect_info_q, vect_err_q, intr_state_q;
    logic [31:0] inject_err_q, wr_entry_info_data, wr_entry_err_data, wr_intr_state_data;
    int          n_fail = 0, check_count = 0;

    vmeer_core #(.LP_ID_W(4)) i_vmeer_core (.*);
    vmeer_monitor_model i_vmeer_monitor_model (.*);

    // 250 MHz clock
    always #2 clk = ~clk;

    // Counts, verdict and end of run
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // One exit; records are sampled two edges after the exit pulse
    task automatic do_exit(input logic ne, vn, un, dv, input logic [2:0] dt, input logic [7:0] v);
        @(posedge clk);
        nmi_exiting     <= ne;
        virtual_nmis    <= vn;
        interrupt_return_unblocked  <= un;
        deliv_active    <= dv;
        deliv_type      <= dt;
        deliv_errv      <= (dt == `VMEER_TYPE_HWEXC);
        nmi_blocked_now <= !un && !dv;
        exit_err_code   <= {24'h00_0000, v};
        exit_vector     <= v;
        deliv_vector    <= v ^ 8'h40;
        exit_evt        <= 1'b1;
        @(posedge clk);
        exit_evt <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
    endtask

    // Monitor services the exit; returns in the cycle of the entry outcome
    task automatic serve(input logic kr, kn, input logic [3:0] lp);
        int n;
        n = 0;
        @(posedge clk);
        go           <= 1'b1;
        keep_rsv     <= kr;
        keep_nmi     <= kn;
        resume_lp_id <= lp;
        @(posedge clk);
        go <= 1'b0;
        while ((entry_ok_q | entry_fail_q) !== 1'b1 && n < 20)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        if (n >= 20)
            n_fail++;
    endtask

    // Unblock flag is withheld for a double fault
    task automatic s_unblock();
        logic [7:0] v;
        for (int k = 0; k < 2; k++)
        begin
            v = k ? `VMEER_VEC_DF : 8'h0e;
            do_exit(1'b0, 1'b0, 1'b1, 1'b0, 3'h3, v);
            `CHK("exit_info", {1'b1, 18'h0, k == 0, 1'b0, 3'h3, v}, exit_info_q)
            `CHK("vect_valid", 1'b0, vect_info_q[31])
            `CHK("exit_err", {24'h00_0000, v}, exit_err_q)
            `CHK("busy", 1'b1, busy_q)
            serve(1'b0, 1'b0, 4'h2);
            `CHK("entry_ok", 1'b1, entry_ok_q)
            `CHK("nmi_restore", k == 0, intr_state_q[3])
            `CHK("no_inject", 1'b0, inject_q)
        end
    endtask

    // Control combinations: {nmi_exiting, virtual_nmis, unblocked, nested}
    task automatic s_vnmi();
        logic [3:0] tbl [4] = '{4'b1110, 4'b1010, 4'b0011, 4'b0100};
        logic       e;
        foreach (tbl[i])
        begin
            e = (!tbl[i][3] || tbl[i][2]) && tbl[i][1] && !tbl[i][0];
            do_exit(tbl[i][3], tbl[i][2], tbl[i][1], tbl[i][0], 3'h3, 8'h0d);
            `CHK("unblock", e, exit_info_q[12])
            serve(1'b0, 1'b0, 4'h2);
        end
    endtask

    // Nested delivery of types 3 to 6 (hardware exception and software), back through entry
    task automatic s_nested();
        logic [2:0] ty [4] = '{3'h3, 3'h4, 3'h5, 3'h6};
        logic       ev;
        foreach (ty[i])
        begin
            ev = (ty[i] == 3'h3);
            do_exit(1'b1, 1'b1, 1'b0, 1'b1, ty[i], 8'h0e);
            `CHK("vect_info", {1'b1, 18'h0, ev, ty[i], 8'h4e}, {vect_info_q[31:13], vect_info_q[11:0]})
            `CHK("vect_err", ev ? 32'h0000_1234 : 32'h0, vect_err_q)
            serve(1'b0, 1'b0, 4'h2);
            `CHK("inject", 1'b1, inject_q)
            `CHK("inj_type", ty[i], inject_type_q)
            `CHK("inj_vec", 8'h4e, inject_vector_q)
            `CHK("inj_err", ev ? 32'h0000_1234 : 32'h0, inject_err_q)
            `CHK("inj_errv", ev, inject_errv_q)
            `CHK("inj_len", ev ? 4'h0 : 4'h3, inject_len_q)
        end
    endtask

    // Reserved bit copied as one, injected NMI still blocked, wrong owner
    task automatic s_refuse();
        do_exit(1'b1, 1'b1, 1'b0, 1'b1, 3'h3, 8'h0e);
        serve(1'b1, 1'b0, 4'h2);
        `CHK("rsv_fail", 1'b1, entry_fail_q)
        serve(1'b0, 1'b0, 4'h2);
        `CHK("rsv_retry", 1'b1, entry_ok_q)
        do_exit(1'b1, 1'b0, 1'b0, 1'b1, `VMEER_TYPE_NMI, 8'h02);
        `CHK("nmi_block", 1'b1, intr_state_q[3])
        serve(1'b0, 1'b1, 4'h2);
        `CHK("nmi_fail", 1'b1, entry_fail_q)
        serve(1'b0, 1'b0, 4'h2);
        `CHK("nmi_type", 3'h2, inject_type_q)
        do_exit(1'b1, 1'b1, 1'b0, 1'b0, 3'h3, 8'h0e);
        serve(1'b0, 1'b0, 4'h5);
        `CHK("owner_fail", 1'b1, entry_fail_q)
        serve(1'b0, 1'b0, 4'h2);
        `CHK("owner_ok", 1'b1, entry_ok_q)
    endtask

    // Reset for four cycles, then every scenario in turn
    initial
    begin
        repeat (4) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        s_unblock();
        s_vnmi();
        s_nested();
        s_refuse();
        print_verdict();
    end

    // Watchdog well beyond the roughly 185 cycles the run needs
    initial
    begin
        #20000;
        n_fail++;
        print_verdict();
    end
endmodule

//--- bench/vmeer_monitor_model.sv
// Behavioural monitor software that services an exit and resumes the guest
`timescale 1ns/1ps
`include "vmeer_defs.svh"

module vmeer_monitor_model
(
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic        go,
    input  wire logic        keep_rsv,
    input  wire logic        keep_nmi,
    input  wire logic        virtual_nmis,
    input  wire logic [31:0] exit_info_q,
    input  wire logic [31:0] vect_info_q,
    input  wire logic [31:0] vect_err_q,
    input  wire logic [3:0]  exit_len_q,
    input  wire logic [31:0] intr_state_q,
    output logic             wr_entry_info,
    output logic [31:0]      wr_entry_info_data,
    output logic             wr_entry_err,
    output logic [31:0]      wr_entry_err_data,
    output logic             wr_entry_len,
    output logic [3:0]       wr_entry_len_data,
    output logic             wr_intr_state,
    output logic [31:0]      wr_intr_state_data,
    output logic             resume_req
);
    logic [2:0] step_q;
    logic       sw_type;
    logic       inj_nmi;

    // Only software events need the instruction length carried over
    assign sw_type = vect_info_q[10:8] inside
        {`VMEER_TYPE_SWINT, `VMEER_TYPE_PSWEXC, `VMEER_TYPE_SWEXC};
    assign inj_nmi = vect_info_q[31] && !virtual_nmis
        && vect_info_q[10:8] == `VMEER_TYPE_NMI;

    // Copy the interrupted event; keep_rsv is a commanded fault on bit 12
    assign wr_entry_info_data = vect_info_q[31]
        ? {1'b1, 18'h0, keep_rsv, vect_info_q[11:0]} : 32'h0;
    assign wr_entry_err_data = vect_info_q[11] ? vect_err_q : 32'h0;
    assign wr_entry_len_data = sw_type ? exit_len_q : 4'h0;

    // Restore or lift NMI blocking; keep_nmi forgets to lift it
    always_comb
    begin
        wr_intr_state_data = intr_state_q;
        if (exit_info_q[12] && !vect_info_q[31])
            wr_intr_state_data[3] = 1'b1;
        if (inj_nmi && !keep_nmi)
            wr_intr_state_data[3] = 1'b0;
    end

    // One field write per cycle, then the resume request
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            step_q <= 3'h0;
        else if (go)
            step_q <= 3'h1;
        else if (step_q != 3'h0)
            step_q <= (step_q == 3'h5) ? 3'h0 : step_q + 3'h1;
    end

    // Strobes follow the step, so each lasts exactly one cycle
    assign wr_intr_state = (step_q == 3'h1);
    assign wr_entry_info = (step_q == 3'h2);
    assign wr_entry_err  = (step_q == 3'h3);
    assign wr_entry_len  = (step_q == 3'h4);
    assign resume_req    = (step_q == 3'h5);
endmodule

//--- core/vmeer_core.sv
// Event recording at guest exit and event delivery at guest entry
//
// Function
// - NMI exiting off: set exit bit 12 for interrupt_return fault that unblocked NMI
// - Virtual NMIs on: set exit bit 12 when interrupt_return removed virtual-NMI blocking
// - Bit 12 set implies blocking was in effect before the faulting interrupt_return
// - Vectoring bit 12 is undefined after every exit
// - Entry fails if entry interruption-info valid bit 31 is set and bits 30:12 are not all zero
// - Vectoring valid bit 31 set when exit arose during event delivery
// - Valid entry interruption info is delivered to the guest at entry
// - Virtual NMIs off and vectoring type NMI: report interruptibility bit 3 as one
// - Injected NMI case fails entry unless monitor cleared interruptibility bit 3
// - Vectoring bit 11 flags a valid vectoring error code
// - One active vm_control_structure controls only one logical processor
`timescale 1ns/1ps
`include "vmeer_defs.svh"

module vmeer_core
    import vmeer_pkg::*;
#(
    parameter int LP_ID_W = 4
)
(
    input  wire logic               clk,
    input  wire logic               arst_n,
    // Execution controls
    input  wire logic               nmi_exiting,
    input  wire logic               virtual_nmis,
    // Exit event from the guest pipeline
    input  wire logic               exit_evt,
    input  wire logic [7:0]         exit_vector,
    input  wire logic [2:0]         exit_type,
    input  wire logic               exit_errv,
    input  wire logic [31:0]        exit_err_code,
    input  wire logic [3:0]         exit_insn_len,
    input  wire logic               interrupt_return_unblocked,
    input  wire logic               nmi_blocked_now,
    input  wire logic               deliv_active,
    input  wire logic [7:0]         deliv_vector,
    input  wire logic [2:0]         deliv_type,
    input  wire logic               deliv_errv,
    input  wire logic [31:0]        deliv_err_code,
    input  wire logic [LP_ID_W-1:0] exit_lp_id,
    // Monitor field writes
    input  wire logic               wr_entry_info,
    input  wire logic [31:0]        wr_entry_info_data,
    input  wire logic               wr_entry_err,
    input  wire logic [31:0]        wr_entry_err_data,
    input  wire logic               wr_entry_len,
    input  wire logic [3:0]         wr_entry_len_data,
    input  wire logic               wr_intr_state,
    input  wire logic [31:0]        wr_intr_state_data,
    // Resume request
    input  wire logic               resume_req,
    input  wire logic [LP_ID_W-1:0] resume_lp_id,
    // Readable exit record
    output logic [31:0]             exit_info_q,
    output logic [31:0]             exit_err_q,
    output logic [31:0]             vect_info_q,
    output logic [31:0]             vect_err_q,
    output logic [3:0]              exit_len_q,
    output logic [31:0]             intr_state_q,
    // Entry outcome
    output logic                    entry_ok_q,
    output logic                    entry_fail_q,
    output logic                    inject_q,
    output logic [7:0]              inject_vector_q,
    output logic [2:0]              inject_type_q,
    output logic                    inject_errv_q,
    output logic [31:0]             inject_err_q,
    output logic [3:0]              inject_len_q,
    output logic                    busy_q
);

    vmeer_state_e       state_q;
    logic [31:0]        entry_info_q;
    logic [31:0]        entry_err_q;
    logic [3:0]         entry_len_q;
    logic [LP_ID_W-1:0] owner_q;
    logic               inj_nmi_q;
    logic               unblk_cond;
    logic               rsv_bad;
    logic               nmi_bad;
    logic               lp_bad;

    // Software-origin types are the only ones that carry an instruction length
    function automatic logic is_sw_type(input logic [2:0] t);
        is_sw_type = (t == `VMEER_TYPE_SWINT) || (t == `VMEER_TYPE_PSWEXC)
                   || (t == `VMEER_TYPE_SWEXC);
    endfunction

    // Unblock indication only when no nested delivery and not a double fault
    assign unblk_cond = interrupt_return_unblocked && !deliv_active
                      && (exit_vector != `VMEER_VEC_DF)
                      && (!nmi_exiting || virtual_nmis);

    // Entry consistency checks
    assign rsv_bad = entry_info_q[`VMEER_VALID_BIT]
                   && (|entry_info_q[`VMEER_RSV_MSB:`VMEER_RSV_LSB]);
    assign nmi_bad = inj_nmi_q && intr_state_q[`VMEER_NMIBLK_BIT];
    assign lp_bad  = (resume_lp_id != owner_q);

    // Sequencer: guest runs until exit, monitor edits, resume is checked
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            state_q <= VMEER_GUEST;
        else
        begin
            case (state_q)
                VMEER_GUEST:   if (exit_evt) state_q <= VMEER_MONITOR;
                VMEER_MONITOR: if (resume_req) state_q <= VMEER_CHECK;
                VMEER_CHECK:   state_q <= (rsv_bad || nmi_bad || lp_bad) ?
                                          VMEER_MONITOR : VMEER_GUEST;
                default:       state_q <= VMEER_GUEST;
            endcase
        end
    end

    // Busy while not running the guest
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            busy_q <= 1'b0;
        else
            busy_q <= (state_q != VMEER_GUEST) || exit_evt;
    end

    // Owning logical processor latched at exit; only it may resume
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            owner_q <= '0;
        else if (state_q == VMEER_GUEST && exit_evt)
            owner_q <= exit_lp_id;
    end

    // Exit interruption record and its error code
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            exit_info_q <= 32'h0000_0000;
            exit_err_q  <= 32'h0000_0000;
            exit_len_q  <= 4'h0;
        end
        else if (state_q == VMEER_GUEST && exit_evt)
        begin
            exit_info_q <= {1'b1, 18'h0_0000, unblk_cond, exit_errv,
                            exit_type, exit_vector};
            exit_err_q  <= exit_err_code;
            exit_len_q  <= exit_insn_len;
        end
    end

    // Vectoring record; bit 12 is left zero though consumers treat it undefined
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            vect_info_q <= 32'h0000_0000;
            vect_err_q  <= 32'h0000_0000;
            inj_nmi_q   <= 1'b0;
        end
        else if (state_q == VMEER_GUEST && exit_evt)
        begin
            vect_info_q <= {deliv_active, 19'h0_0000, deliv_errv,
                            deliv_type, deliv_vector};
            vect_err_q  <= deliv_errv ? deliv_err_code : 32'h0000_0000;
            inj_nmi_q   <= deliv_active && !virtual_nmis
                         && (deliv_type == `VMEER_TYPE_NMI);
        end
    end

    // Interruptibility state: hardware sets NMI blocking at exit, monitor edits after
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            intr_state_q <= 32'h0000_0000;
        else if (state_q == VMEER_GUEST && exit_evt)
        begin
            intr_state_q <= 32'h0000_0000;
            intr_state_q[`VMEER_NMIBLK_BIT] <= nmi_blocked_now
                || (deliv_active && !virtual_nmis
                    && deliv_type == `VMEER_TYPE_NMI);
        end
        else if (state_q == VMEER_MONITOR && wr_intr_state)
            intr_state_q <= wr_intr_state_data;
    end

    // Entry fields written by the monitor; valid bit consumed by a good entry
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            entry_info_q <= 32'h0000_0000;
            entry_err_q  <= 32'h0000_0000;
            entry_len_q  <= 4'h0;
        end
        else if (state_q == VMEER_MONITOR)
        begin
            if (wr_entry_info)
                entry_info_q <= wr_entry_info_data;
            if (wr_entry_err)
                entry_err_q <= wr_entry_err_data;
            if (wr_entry_len)
                entry_len_q <= wr_entry_len_data;
        end
        else if (state_q == VMEER_CHECK && !(rsv_bad || nmi_bad || lp_bad))
            entry_info_q[`VMEER_VALID_BIT] <= 1'b0;
    end

    // Entry outcome and injected event, one-cycle pulses
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            entry_ok_q      <= 1'b0;
            entry_fail_q    <= 1'b0;
            inject_q        <= 1'b0;
            inject_vector_q <= 8'h00;
            inject_type_q   <= 3'h0;
            inject_errv_q   <= 1'b0;
            inject_err_q    <= 32'h0000_0000;
            inject_len_q    <= 4'h0;
        end
        else
        begin
            entry_ok_q   <= 1'b0;
            entry_fail_q <= 1'b0;
            inject_q     <= 1'b0;
            if (state_q == VMEER_CHECK)
            begin
                entry_fail_q <= rsv_bad || nmi_bad || lp_bad;
                entry_ok_q   <= !(rsv_bad || nmi_bad || lp_bad);
                if (!(rsv_bad || nmi_bad || lp_bad) && entry_info_q[`VMEER_VALID_BIT])
                begin
                    inject_q        <= 1'b1;
                    inject_vector_q <= entry_info_q[`VMEER_VEC_MSB:`VMEER_VEC_LSB];
                    inject_type_q   <= entry_info_q[`VMEER_TYPE_MSB:`VMEER_TYPE_LSB];
                    inject_errv_q   <= entry_info_q[`VMEER_ERRV_BIT];
                    inject_err_q    <= entry_info_q[`VMEER_ERRV_BIT] ?
                                       entry_err_q : 32'h0000_0000;
                    inject_len_q    <= is_sw_type(
                        entry_info_q[`VMEER_TYPE_MSB:`VMEER_TYPE_LSB]) ?
                        entry_len_q : 4'h0;
                end
            end
        end
    end

    // Checks on the recorded and delivered events
    unblk_cause_a: assert property (@(posedge clk) disable iff (!arst_n)
        (state_q == VMEER_GUEST && exit_evt) |=> exit_info_q[`VMEER_UNBLK_BIT] == $past(unblk_cond))
        else $error("exit bit 12 mismatch");
    unblk_df_a: assert property (@(posedge clk) disable iff (!arst_n)
        (state_q == VMEER_GUEST && exit_evt && exit_vector == `VMEER_VEC_DF)
        |=> !exit_info_q[`VMEER_UNBLK_BIT])
        else $error("bit 12 set on double fault");
    vect_valid_a: assert property (@(posedge clk) disable iff (!arst_n)
        (state_q == VMEER_GUEST && exit_evt) |=> vect_info_q[`VMEER_VALID_BIT] == $past(deliv_active))
        else $error("vectoring valid wrong");
    rsv_fail_a: assert property (@(posedge clk) disable iff (!arst_n)
        (state_q == VMEER_CHECK && rsv_bad) |=> entry_fail_q && !inject_q)
        else $error("reserved bits not refused");
    nmi_fail_a: assert property (@(posedge clk) disable iff (!arst_n)
        (state_q == VMEER_CHECK && nmi_bad) |=> entry_fail_q)
        else $error("nmi blocking not refused");
    inject_a: assert property (@(posedge clk) disable iff (!arst_n)
        (state_q == VMEER_CHECK && !rsv_bad && !nmi_bad && !lp_bad
         && entry_info_q[`VMEER_VALID_BIT]) |=> inject_q ##1 state_q == VMEER_GUEST)
        else $error("valid event not injected");
    nmi_state_a: assert property (@(posedge clk) disable iff (!arst_n)
        (state_q == VMEER_GUEST && exit_evt && deliv_active && !virtual_nmis
         && deliv_type == `VMEER_TYPE_NMI) |=> intr_state_q[`VMEER_NMIBLK_BIT])
        else $error("nmi blocking not reported");
    one_lp_a: assert property (@(posedge clk) disable iff (!arst_n)
        (state_q == VMEER_CHECK && resume_lp_id != owner_q) |=> entry_fail_q)
        else $error("foreign processor resumed");
    errv_a: assert property (@(posedge clk) disable iff (!arst_n)
        (state_q == VMEER_GUEST && exit_evt && !deliv_errv) |=> vect_err_q == 32'h0000_0000)
        else $error("error code without valid flag");
    ok_c: cover property (@(posedge clk) disable iff (!arst_n) entry_ok_q && inject_q);
    fail_c: cover property (@(posedge clk) disable iff (!arst_n) entry_fail_q);
    unblk_c: cover property (@(posedge clk) disable iff (!arst_n)
        exit_info_q[`VMEER_UNBLK_BIT] && state_q == VMEER_MONITOR);
    nmi_fail_c: cover property (@(posedge clk) disable iff (!arst_n)
        entry_fail_q && inj_nmi_q);
    sw_len_c: cover property (@(posedge clk) disable iff (!arst_n)
        inject_q && inject_len_q != 4'h0);

    // Bit 12 only means something when no nested delivery and no double fault
    unblk_cond_a: assert property (@(posedge clk) disable iff (!arst_n)
        exit_info_q[`VMEER_UNBLK_BIT] |-> !vect_info_q[`VMEER_VALID_BIT]
        && exit_info_q[`VMEER_VEC_MSB:`VMEER_VEC_LSB] != `VMEER_VEC_DF)
        else $error("bit 12 reported outside its conditions");
    inj_err_a: assert property (@(posedge clk) disable iff (!arst_n)
        (inject_q && !inject_errv_q) |-> inject_err_q == 32'h0000_0000)
        else $error("injected error code without valid flag");

endmodule

//--- core/vmeer_defs.svh
// Field positions and encodings for the exit and entry event records
`ifndef VMEER_DEFS_SVH
`define VMEER_DEFS_SVH
`define VMEER_VEC_LSB      0
`define VMEER_VEC_MSB      7
`define VMEER_TYPE_LSB     8
`define VMEER_TYPE_MSB     10
`define VMEER_ERRV_BIT     11
`define VMEER_UNBLK_BIT    12
`define VMEER_RSV_LSB      12
`define VMEER_RSV_MSB      30
`define VMEER_VALID_BIT    31
`define VMEER_NMIBLK_BIT   3
`define VMEER_VEC_DF       8'h08
`define VMEER_TYPE_NMI     3'h2
`define VMEER_TYPE_HWEXC   3'h3
`define VMEER_TYPE_SWINT   3'h4
`define VMEER_TYPE_PSWEXC  3'h5
`define VMEER_TYPE_SWEXC   3'h6
`endif

//--- core/vmeer_pkg.sv
// Types shared by the event reinjection logic
package vmeer_pkg;
    typedef enum logic [1:0] {
        VMEER_GUEST,
        VMEER_MONITOR,
        VMEER_CHECK
    } vmeer_state_e;
endpackage
